// File: src/can_mailbox_filter_status.sv
// mailbox type, acceptance filter, family code and status words of a can controller
// assumes an apb master on clk and a protocol core on clk that reports frames as pulses
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "can_mbox_map.svh"

module can_mailbox_filter_status #(
	parameter int MB_COUNT = 8,
	parameter int IDX_W = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire can_mbox_pkg::rx_frame_t rx_frame,
	input wire logic frame_start,
	input wire logic [15:0] timer_value,
	input wire logic tx_done,
	input wire logic [IDX_W-1:0] tx_done_index,
	output logic [MB_COUNT-1:0] tx_request,
	output logic [MB_COUNT-1:0] tx_remote,
	output logic [MB_COUNT-1:0] data_unlocked,
	output logic [MB_COUNT-1:0] abort_event,
	output logic rx_accept,
	output logic [IDX_W-1:0] rx_accept_index
);

	typedef struct packed {
		can_mbox_pkg::mb_state_t [MB_COUNT-1:0] mb;
		can_mbox_pkg::apb_answer_t bus;
		logic [1:0] cfg;
		logic [15:0] start_time;
		logic rx_accept;
		logic [IDX_W-1:0] rx_accept_index;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic [MB_COUNT-1:0] match;
	logic [MB_COUNT-1:0] takes_data;
	logic [MB_COUNT-1:0] win;
	logic [28:0] family [MB_COUNT];

	// per mailbox filter and family code
	genvar g;
	generate
		for (g = 0; g < MB_COUNT; g++) begin : gen_mb
			can_mbox_pkg::mb_state_t m;
			logic [28:0] want;
			logic [28:0] care;
			logic kind_live;
			logic [28:0] pick;
			assign m = state_reg.mb[g];
			// family selection ignores the mask version, which only gates matching
			assign pick = {m.mask_std, m.mask_ext};
			assign want = {m.standard_id_bits,
				m.id_version_select ? m.extended_id_bits : 18'h0_0000};
			assign care = {m.mask_std, m.mask_version ? m.mask_ext : 18'h0_0000};
			assign kind_live = m.object_kind inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
			assign match[g] = kind_live && rx_frame.valid
				&& (rx_frame.ide == m.id_version_select)
				&& (((rx_frame.id ^ want) & care) == 29'h0000_0000);
			// who may store a data frame
			always_comb begin
				takes_data[g] = 1'b0;
				// receive kinds store remote frames too, so their remote flag can follow them
				if (match[g]) begin
					case (m.object_kind)
						can_mbox_pkg::KIND_RECEIVE: takes_data[g] = !m.mailbox_ready_flag;
						can_mbox_pkg::KIND_OVERWRITE: takes_data[g] = 1'b1;
						can_mbox_pkg::KIND_CONSUMER: takes_data[g] = m.wait_rx && !rx_frame.rtr;
						default: takes_data[g] = 1'b0;
					endcase
				end
			end
			always_comb begin
				logic [4:0] pos;
				pos = 5'h00;
				family[g] = 29'h0000_0000;
				for (int b = 0; b < 29; b++) begin
					if (pick[b]) begin
						family[g][pos] = want[b];
						pos = pos + 5'h01;
					end
				end
			end
		end
	endgenerate

	// lowest numbered taker wins a data frame
	assign win = takes_data & (~takes_data + MB_COUNT'(1));

	always_comb begin
		logic access;
		logic [IDX_W-1:0] sel;
		logic hit_mb;
		logic [4:0] reg_off;
		logic [15:0] stamp;
		logic [31:0] rd;
		logic mapped;
		state_next = state_reg;
		access = psel && penable && state_reg.bus.pready;
		sel = paddr[`MB_STRIDE_LSB+IDX_W-1:`MB_STRIDE_LSB];
		reg_off = paddr[4:0];
		hit_mb = (paddr[11:8] == 4'(`MB_BASE_OFFSET >> 8))
			&& ({1'b0, paddr[7:`MB_STRIDE_LSB]} < 4'(MB_COUNT));
		state_next.rx_accept = 1'b0;
		state_next.rx_accept_index = state_reg.rx_accept_index;
		if (frame_start) begin
			state_next.start_time = timer_value;
		end
		if (state_reg.cfg[`CFG_TIME_TRIGGER_BIT]) begin
			stamp = 16'h0000;
		end else if (state_reg.cfg[`CFG_FRAME_END_BIT]) begin
			stamp = timer_value;
		end else begin
			stamp = state_reg.start_time;
		end

		// answer one cycle into the access phase
		rd = 32'h0000_0000;
		mapped = 1'b0;
		if (paddr == `CFG_OFFSET) begin
			mapped = 1'b1;
			rd[1:0] = state_reg.cfg;
		end else if (hit_mb) begin
			mapped = reg_off inside {`MB_MODE_OFFSET, `MB_MASK_OFFSET, `MB_ID_OFFSET,
				`MB_FAMILY_OFFSET, `MB_STATUS_OFFSET, `MB_CONTROL_OFFSET};
			case (reg_off)
				`MB_MODE_OFFSET: rd[`KIND_MSB:`KIND_LSB] = state_reg.mb[sel].object_kind;
				`MB_MASK_OFFSET: rd[29:0] = {state_reg.mb[sel].mask_version,
					state_reg.mb[sel].mask_std, state_reg.mb[sel].mask_ext};
				`MB_ID_OFFSET: rd[29:0] = {state_reg.mb[sel].id_version_select,
					state_reg.mb[sel].standard_id_bits,
					state_reg.mb[sel].id_version_select ?
					state_reg.mb[sel].extended_id_bits : 18'h0_0000};
				`MB_FAMILY_OFFSET: rd[28:0] = family[sel];
				`MB_STATUS_OFFSET: rd = {7'h00, state_reg.mb[sel].message_ignored_flag,
					state_reg.mb[sel].mailbox_ready_flag, state_reg.mb[sel].abort_done_flag,
					1'b0, state_reg.mb[sel].remote_request_flag,
					state_reg.mb[sel].length_code, state_reg.mb[sel].frame_time_capture};
				default: rd = 32'h0000_0000;
			endcase
		end
		state_next.bus.pready = psel && penable && !state_reg.bus.pready;
		if (psel && penable && !state_reg.bus.pready) begin
			state_next.bus.prdata = pwrite ? 32'h0000_0000 : rd;
			state_next.bus.pslverr = !mapped;
		end else begin
			state_next.bus.prdata = 32'h0000_0000;
			state_next.bus.pslverr = 1'b0;
		end

		// software side, applied before hardware events so a set wins
		if (access && pwrite && paddr == `CFG_OFFSET) begin
			state_next.cfg = pwdata[1:0];
		end
		if (access && hit_mb) begin
			if (!pwrite && reg_off == `MB_STATUS_OFFSET) begin
				state_next.mb[sel].message_ignored_flag = 1'b0;
			end
			if (pwrite) begin
				case (reg_off)
					`MB_MODE_OFFSET: begin
						state_next.mb[sel].object_kind = pwdata[`KIND_MSB:`KIND_LSB];
						state_next.mb[sel].send_pending = 1'b0;
						state_next.mb[sel].send_remote = 1'b0;
						state_next.mb[sel].wait_rx = 1'b0;
						state_next.mb[sel].mailbox_ready_flag =
							pwdata[`KIND_MSB:`KIND_LSB] inside {3'h3, 3'h5};
						state_next.mb[sel].remote_request_flag =
							(pwdata[`KIND_MSB:`KIND_LSB] == can_mbox_pkg::KIND_CONSUMER);
					end
					// software must disable first; no lock here
					`MB_MASK_OFFSET: begin
						state_next.mb[sel].mask_version = pwdata[`VERSION_BIT];
						state_next.mb[sel].mask_std = pwdata[`STD_MSB:`STD_LSB];
						state_next.mb[sel].mask_ext = pwdata[`EXT_MSB:`EXT_LSB];
					end
					`MB_ID_OFFSET: begin
						state_next.mb[sel].id_version_select = pwdata[`VERSION_BIT];
						state_next.mb[sel].standard_id_bits = pwdata[`STD_MSB:`STD_LSB];
						state_next.mb[sel].extended_id_bits = pwdata[`EXT_MSB:`EXT_LSB];
					end
					`MB_CONTROL_OFFSET: begin
						if (pwdata[`TRANSFER_CMD_BIT] || pwdata[`ABORT_CMD_BIT]) begin
							state_next.mb[sel].mailbox_ready_flag = 1'b0;
							state_next.mb[sel].abort_done_flag = 1'b0;
						end
						if (pwdata[`TRANSFER_CMD_BIT]) begin
							case (state_reg.mb[sel].object_kind)
								can_mbox_pkg::KIND_TRANSMIT: begin
									state_next.mb[sel].send_pending = 1'b1;
								end
								can_mbox_pkg::KIND_CONSUMER: begin
									state_next.mb[sel].send_pending = 1'b1;
									state_next.mb[sel].send_remote = 1'b1;
									state_next.mb[sel].wait_rx = 1'b0;
								end
								// arm and keep length to send
								can_mbox_pkg::KIND_PRODUCER: begin
									state_next.mb[sel].wait_rx = 1'b1;
									state_next.mb[sel].length_code = pwdata[`DLC_MSB:`DLC_LSB];
								end
								default: state_next.mb[sel].wait_rx = 1'b0;
							endcase
						end
						if (pwdata[`ABORT_CMD_BIT]
							&& state_reg.mb[sel].object_kind inside {3'h3, 3'h4, 3'h5}
							&& (state_next.mb[sel].send_pending || state_next.mb[sel].wait_rx)) begin
							state_next.mb[sel].send_pending = 1'b0;
							state_next.mb[sel].send_remote = 1'b0;
							state_next.mb[sel].wait_rx = 1'b0;
							state_next.mb[sel].abort_done_flag = 1'b1;
							state_next.mb[sel].frame_time_capture = stamp;
						end
					end
					default: state_next.mb[sel].object_kind = state_reg.mb[sel].object_kind;
				endcase
			end
		end

		// protocol core events
		for (int i = 0; i < MB_COUNT; i++) begin
			if (match[i]) begin
				case (state_reg.mb[i].object_kind)
					// full receive mailbox drops the frame
					can_mbox_pkg::KIND_RECEIVE: begin
						if (state_reg.mb[i].mailbox_ready_flag) begin
							state_next.mb[i].message_ignored_flag = 1'b1;
						end
					end
					can_mbox_pkg::KIND_OVERWRITE: begin
						if (state_reg.mb[i].mailbox_ready_flag) begin
							state_next.mb[i].message_ignored_flag = 1'b1;
						end
					end
					can_mbox_pkg::KIND_CONSUMER: begin
						if (!state_reg.mb[i].wait_rx && state_reg.mb[i].mailbox_ready_flag
							&& !rx_frame.rtr) begin
							state_next.mb[i].message_ignored_flag = 1'b1;
						end
					end
					can_mbox_pkg::KIND_PRODUCER: begin
						if (rx_frame.rtr && state_next.mb[i].wait_rx) begin
							state_next.mb[i].wait_rx = 1'b0;
							state_next.mb[i].send_pending = 1'b1;
						end else if (rx_frame.rtr) begin
							state_next.mb[i].message_ignored_flag = 1'b1;
						end
					end
					default: state_next.mb[i].message_ignored_flag =
						state_next.mb[i].message_ignored_flag;
				endcase
			end
			if (win[i]) begin
				state_next.mb[i].mailbox_ready_flag = 1'b1;
				state_next.mb[i].wait_rx = 1'b0;
				state_next.mb[i].length_code = rx_frame.dlc;
				state_next.mb[i].frame_time_capture = stamp;
				if (state_reg.mb[i].object_kind != can_mbox_pkg::KIND_CONSUMER) begin
					state_next.mb[i].remote_request_flag = rx_frame.rtr;
				end
				state_next.rx_accept = 1'b1;
				state_next.rx_accept_index = IDX_W'(i);
			end
			if (tx_done && tx_done_index == IDX_W'(i) && state_reg.mb[i].send_pending) begin
				state_next.mb[i].send_pending = 1'b0;
				state_next.mb[i].send_remote = 1'b0;
				state_next.mb[i].frame_time_capture = stamp;
				if (state_reg.mb[i].object_kind == can_mbox_pkg::KIND_CONSUMER) begin
					state_next.mb[i].wait_rx = 1'b1;
				end else begin
					state_next.mb[i].mailbox_ready_flag = 1'b1;
				end
			end
			if (state_reg.cfg[`CFG_TIME_TRIGGER_BIT]) begin
				state_next.mb[i].frame_time_capture = 16'h0000;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.cfg <= `CFG_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		for (int i = 0; i < MB_COUNT; i++) begin
			tx_request[i] = state_reg.mb[i].send_pending;
			tx_remote[i] = state_reg.mb[i].send_remote;
			data_unlocked[i] = state_reg.mb[i].mailbox_ready_flag;
			abort_event[i] = state_reg.mb[i].abort_done_flag;
		end
	end

	assign prdata = state_reg.bus.prdata;
	assign pready = state_reg.bus.pready;
	assign pslverr = state_reg.bus.pslverr;
	assign rx_accept = state_reg.rx_accept;
	assign rx_accept_index = state_reg.rx_accept_index;

endmodule
`default_nettype wire

// File: src/can_mbox_map.svh
// register offsets, field positions and reset values of the mailbox block
// assumes byte addresses on a 32-bit apb bus, one aligned word per register
`ifndef CAN_MBOX_MAP_SVH
`define CAN_MBOX_MAP_SVH

`define CFG_OFFSET 12'h000
`define MB_BASE_OFFSET 12'h200
`define MB_STRIDE_LSB 5
`define MB_MODE_OFFSET 5'h00
`define MB_MASK_OFFSET 5'h04
`define MB_ID_OFFSET 5'h08
`define MB_FAMILY_OFFSET 5'h0C
`define MB_STATUS_OFFSET 5'h10
`define MB_CONTROL_OFFSET 5'h1C

`define CFG_TIME_TRIGGER_BIT 0
`define CFG_FRAME_END_BIT 1

`define KIND_LSB 24
`define KIND_MSB 26
`define VERSION_BIT 29
`define STD_MSB 28
`define STD_LSB 18
`define EXT_MSB 17
`define EXT_LSB 0

`define IGNORED_BIT 24
`define READY_BIT 23
`define ABORT_BIT 22
`define RTR_BIT 20
`define DLC_MSB 19
`define DLC_LSB 16
`define STAMP_MSB 15

`define TRANSFER_CMD_BIT 23
`define ABORT_CMD_BIT 22

`define CFG_RESET 2'b00
`define KIND_RESET 3'h0

`endif

// File: src/can_mbox_pkg.sv
// types of the mailbox filter and status block
// constants live in can_mbox_map.svh
package can_mbox_pkg;

	typedef enum logic [2:0] {
		KIND_DISABLED = 3'b000,
		KIND_RECEIVE = 3'b001,
		KIND_OVERWRITE = 3'b010,
		KIND_TRANSMIT = 3'b011,
		KIND_CONSUMER = 3'b100,
		KIND_PRODUCER = 3'b101
	} object_kind_t;

	typedef struct packed {
		logic valid;
		logic [28:0] id;
		logic ide;
		logic rtr;
		logic [3:0] dlc;
	} rx_frame_t;

	typedef struct packed {
		logic [2:0] object_kind;
		logic mask_version;
		logic [10:0] mask_std;
		logic [17:0] mask_ext;
		logic id_version_select;
		logic [10:0] standard_id_bits;
		logic [17:0] extended_id_bits;
		logic message_ignored_flag;
		logic mailbox_ready_flag;
		logic abort_done_flag;
		logic remote_request_flag;
		logic [3:0] length_code;
		logic [15:0] frame_time_capture;
		logic send_pending;
		logic send_remote;
		logic wait_rx;
	} mb_state_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_answer_t;

endpackage

// File: tb/can_bus_node.sv
// other nodes on the can bus: frames to the block, send completions back
// assumes the block holds tx_request per mailbox until its send is done
`timescale 1ns/100ps
`default_nettype none
module can_bus_node (
	input wire logic clk,
	input wire logic [7:0] tx_request,
	output var can_mbox_pkg::rx_frame_t rx_frame,
	output var logic frame_start,
	output var logic [15:0] timer_value,
	output var logic tx_done,
	output var logic [2:0] tx_done_index
);
	int delay = 5;
	int cnt = 0;
	logic busy = 1'b0;
	logic [15:0] t_start;
	logic [15:0] t_end;
	initial begin
		rx_frame = '0;
		frame_start = 1'b0;
		timer_value = 16'h0000;
		tx_done = 1'b0;
		tx_done_index = 3'h0;
	end
	// a send lasts delay+1 cycles; one no longer requested at its end never completes
	always @(posedge clk) begin
		timer_value <= timer_value + 16'h0001;
		tx_done <= 1'b0;
		if (frame_start)
			t_start <= timer_value;
		if (rx_frame.valid)
			t_end <= timer_value;
		if (!busy && tx_request != 8'h00) begin
			busy <= 1'b1;
			cnt <= delay;
			for (int i = 7; i >= 0; i--)
				if (tx_request[i]) tx_done_index <= 3'(i);
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end else if (busy) begin
			busy <= 1'b0;
			tx_done <= tx_request[tx_done_index];
		end
	end
	// idle bus shows the inverse, never the last frame
	task automatic send(input can_mbox_pkg::rx_frame_t f);
		frame_start <= 1'b1;
		@(posedge clk);
		frame_start <= 1'b0;
		repeat (3) @(posedge clk);
		rx_frame <= f;
		@(posedge clk);
		rx_frame <= {1'b0, ~f[34:0]};
	endtask
endmodule
`default_nettype wire

// File: tb/can_mbox_props.sv
// checker of the mailbox block, bound to its top module
// assumes one clock and the async active-low reset of the block
`timescale 1ns/100ps
`default_nettype none
module can_mbox_props #(
	parameter int MB_COUNT = 8,
	parameter int IDX_W = 3
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire can_mbox_pkg::rx_frame_t rx_frame,
	input wire logic tx_done,
	input wire logic [IDX_W-1:0] tx_done_index,
	input wire logic [MB_COUNT-1:0] tx_request,
	input wire logic [MB_COUNT-1:0] data_unlocked,
	input wire logic [MB_COUNT-1:0] abort_event,
	input wire logic rx_accept
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// a write takes effect only at the edge that completes it
	wire wr_done = psel && penable && pready && pwrite;
	a_accept_cause: assert property (rx_accept |-> $past(rx_frame.valid))
		else $error("frame accepted with no frame received");
	a_accept_single: assert property (rx_accept && !rx_frame.valid |=> !rx_accept)
		else $error("one frame accepted twice");
	a_done_clears_req: assert property (tx_done && tx_request[tx_done_index] && !wr_done
		|=> !tx_request[$past(tx_done_index)]) else $error("send request kept after done");
	a_unlock_cause: assert property ((data_unlocked & ~$past(data_unlocked)) != '0
		|-> $past(tx_done) || $past(rx_frame.valid) || $past(wr_done))
		else $error("ready set with no cause");
	a_abort_cause: assert property ((abort_event & ~$past(abort_event)) != '0
		|-> $past(wr_done)) else $error("abort set with no command");
	a_abort_clear: assert property ((~abort_event & $past(abort_event)) != '0
		|-> $past(wr_done)) else $error("abort cleared with no command");
	a_ready_clear: assert property ((~data_unlocked & $past(data_unlocked)) != '0
		|-> $past(wr_done)) else $error("ready cleared with no command");
	a_req_cause: assert property ((tx_request & ~$past(tx_request)) != '0
		|-> $past(wr_done) || $past(rx_frame.valid)) else $error("send request with no cause");
endmodule
bind can_mailbox_filter_status can_mbox_props #(.MB_COUNT(MB_COUNT), .IDX_W(IDX_W)) u_props (
	.clk(clk),
	.reset_n(reset_n),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pready(pready),
	.rx_frame(rx_frame),
	.tx_done(tx_done),
	.tx_done_index(tx_done_index),
	.tx_request(tx_request),
	.data_unlocked(data_unlocked),
	.abort_event(abort_event),
	.rx_accept(rx_accept)
);
`default_nettype wire

// File: tb/tb_can_mailbox_filter_status.sv
// bench of the mailbox block: apb register tasks and a bus node model
// assumes mailbox i at 0x200 + 0x20*i and config at 0x000
`timescale 1ns/100ps
`default_nettype none
`include "can_mbox_map.svh"
module tb_can_mailbox_filter_status;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] q;
	logic pready, pslverr, frame_start, tx_done, rx_accept, err;
	logic [15:0] timer_value;
	logic [15:0] stamp;
	logic [2:0] tx_done_index, rx_accept_index, last_idx;
	logic [7:0] tx_request, tx_remote, data_unlocked, abort_event;
	can_mbox_pkg::rx_frame_t rx_frame;
	int n_mismatch = 0;
	int comparisons = 0;
	int n_acc = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	can_mailbox_filter_status u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_frame(rx_frame), .frame_start(frame_start),
		.timer_value(timer_value), .tx_done(tx_done), .tx_done_index(tx_done_index),
		.tx_request(tx_request), .tx_remote(tx_remote), .data_unlocked(data_unlocked),
		.abort_event(abort_event), .rx_accept(rx_accept), .rx_accept_index(rx_accept_index));
	can_bus_node u_node (.clk(clk), .tx_request(tx_request), .rx_frame(rx_frame),
		.frame_start(frame_start), .timer_value(timer_value), .tx_done(tx_done),
		.tx_done_index(tx_done_index));
	task results();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rx_accept === 1'b1) begin
			n_acc <= n_acc + 1;
			last_idx <= rx_accept_index;
		end
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", n, exp, got);
			n_mismatch++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [11:0] ad(input int i, input logic [4:0] o);
		return `MB_BASE_OFFSET + 12'(i * 32) + {7'h00, o};
	endfunction
	function automatic logic [15:0] up(input logic ig, rd, ab, rt, input logic [3:0] dl);
		return {7'h00, ig, rd, ab, 1'b0, rt, dl};
	endfunction
	task automatic setup(input int i, input logic [2:0] k);
		apb(1'b1, ad(i, `MB_MODE_OFFSET), 32'h0000_0000);
		apb(1'b1, ad(i, `MB_MASK_OFFSET), 32'h1FFC_0000);
		apb(1'b1, ad(i, `MB_ID_OFFSET), {3'b000, 11'h100 + 11'(i), 18'h0_0000});
		apb(1'b1, ad(i, `MB_MODE_OFFSET), {5'h00, k, 24'h00_0000});
	endtask
	// extended bits set: ignored while mask version is 0
	task automatic fr(input int i, input logic r, input logic [3:0] l);
		u_node.send({1'b1, 11'h100 + 11'(i), 18'h0_0001, 1'b0, r, l});
		tick(2);
	endtask
	task automatic st(input int i);
		apb(1'b0, ad(i, `MB_STATUS_OFFSET), 32'h0000_0000);
	endtask
	task automatic wait_done(input int i);
		for (int t = 0; t < 300 && tx_request[i] !== 1'b0; t++) @(posedge clk);
	endtask
	initial begin
		tick(5);
		reset_n <= 1'b1;
		apb(1'b0, 12'h100, 32'h0000_0000);
		chk("unmapped err", err, 1'b1);
		chk("unmapped rd", q, 32'h0000_0000);
		apb(1'b1, ad(7, `MB_ID_OFFSET), 32'h305A_4321);
		apb(1'b1, ad(7, `MB_MASK_OFFSET), 32'h1000_0F0F);
		apb(1'b0, ad(7, `MB_FAMILY_OFFSET), 32'h0000_0000);
		chk("family", q, 32'h0000_0131);
		apb(1'b0, ad(7, `MB_MASK_OFFSET), 32'h0000_0000);
		chk("mask", q, 32'h1000_0F0F);
		apb(1'b1, ad(7, `MB_ID_OFFSET), 32'h105A_4321);
		apb(1'b0, ad(7, `MB_ID_OFFSET), 32'h0000_0000);
		chk("std id", q, 32'h1058_0000);
		// mailbox 6 receives for the timestamp checks; 7 holds a reserved kind
		for (int i = 0; i < 8; i++) setup(i, (i == 7) ? 3'h6 : ((i == 6) ? 3'h1 : 3'(i)));
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ad(i, `MB_MODE_OFFSET), 32'h0000_0000);
			chk("kind", q, 32'(i) << 24);
		end
		st(4);
		chk("rtr cons", q[20], 1'b1);
		st(5);
		chk("rtr prod", q[20], 1'b0);
		fr(0, 1'b0, 4'h1);
		fr(7, 1'b0, 4'h1);
		chk("off kinds", n_acc, 0);
		fr(1, 1'b0, 4'h3);
		stamp = u_node.t_start;
		chk("rx idx", last_idx, 3'h1);
		chk("unlock", data_unlocked[1], 1'b1);
		st(1);
		chk("rx st", q, {up(1'b0, 1'b1, 1'b0, 1'b0, 4'h3), stamp});
		fr(1, 1'b1, 4'h5);
		st(1);
		chk("rx full", q[31:16], up(1'b1, 1'b1, 1'b0, 1'b0, 4'h3));
		st(1);
		chk("ign clr", q[24], 1'b0);
		fr(2, 1'b0, 4'h2);
		fr(2, 1'b1, 4'h7);
		st(2);
		chk("ovw st", q[31:16], up(1'b1, 1'b1, 1'b0, 1'b1, 4'h7));
		chk("n acc", n_acc, 3);
		apb(1'b1, ad(1, `MB_CONTROL_OFFSET), 32'h0080_0000);
		st(1);
		chk("rdy clr", q[23], 1'b0);
		apb(1'b1, ad(3, `MB_CONTROL_OFFSET), 32'h0080_0000);
		tick(2);
		chk("tx req", tx_request[3], 1'b1);
		wait_done(3);
		st(3);
		chk("tx st", q[23:22], 2'b10);
		u_node.delay = 60;
		apb(1'b1, ad(3, `MB_CONTROL_OFFSET), 32'h0080_0000);
		apb(1'b1, ad(3, `MB_CONTROL_OFFSET), 32'h0040_0000);
		tick(2);
		chk("abort", {abort_event[3], tx_request[3]}, 2'b10);
		st(3);
		chk("abort st", q[23:22], 2'b01);
		u_node.delay = 5;
		apb(1'b1, ad(3, `MB_CONTROL_OFFSET), 32'h0080_0000);
		tick(1);
		chk("abort clr", abort_event[3], 1'b0);
		wait_done(3);
		apb(1'b1, ad(4, `MB_CONTROL_OFFSET), 32'h0080_0000);
		tick(2);
		chk("remote", {tx_request[4], tx_remote[4]}, 2'b11);
		wait_done(4);
		fr(4, 1'b0, 4'h4);
		st(4);
		chk("cons st", {last_idx, q[23], q[19:16]}, {3'h4, 1'b1, 4'h4});
		apb(1'b1, ad(5, `MB_CONTROL_OFFSET), 32'h0086_0000);
		tick(2);
		chk("prod wait", tx_request[5], 1'b0);
		fr(5, 1'b1, 4'h0);
		chk("prod req", tx_request[5], 1'b1);
		wait_done(5);
		st(5);
		chk("prod st", {q[23], q[19:16]}, {1'b1, 4'h6});
		apb(1'b1, `CFG_OFFSET, 32'h0000_0001);
		fr(6, 1'b0, 4'h1);
		st(6);
		chk("tt stamp", q[15:0], 16'h0000);
		apb(1'b1, ad(6, `MB_CONTROL_OFFSET), 32'h0080_0000);
		apb(1'b1, `CFG_OFFSET, 32'h0000_0002);
		fr(6, 1'b0, 4'h1);
		st(6);
		chk("eof stamp", q[15:0], u_node.t_end);
		results();
	end
endmodule
`default_nettype wire
